// File: rtl/gces_cfg.svh
// Purpose: Offsets, field positions, reset values and counts for the control/event bank
// Assumes: Byte-addressed configuration space, byte-wide accesses
// Notes:   Definitions only
`ifndef GCES_CFG_SVH
`define GCES_CFG_SVH
`define GCES_OFF_GEN_CTRL_LO 8'h86
`define GCES_OFF_GEN_CTRL_HI 8'h87
`define GCES_OFF_EVT_STS     8'h88
`define GCES_OFF_EVT_EN      8'h89
`define GCES_OFF_GPIO_CFG    8'h8c
`define GCES_GC_RESET        16'h0080
`define GCES_GC_WMASK        16'h3c3b
`define GCES_GC_ARB_LSB      0
`define GCES_GC_FW_OFF       3
`define GCES_GC_SKTB_OFF     4
`define GCES_GC_MEDIA_OFF    5
`define GCES_GC_REV          7
`define GCES_GC_HV_SW        10
`define GCES_GC_IOBASE       11
`define GCES_GC_IOLIM        12
`define GCES_GC_FAST_SIM     13
`define GCES_ES_RESET        8'h00
`define GCES_ES_MASK         8'hdf
`define GCES_ES_PWR          7
`define GCES_ES_VPP          6
`define GCES_QUERY_NORM      16'h0fff
`define GCES_QUERY_FAST      16'h000f
`endif

// File: rtl/gces_pkg.sv
// Purpose: Types for the control/event bank
// Assumes: Nothing beyond the cfg header
// Notes:   Arbitration codes follow the register field encoding
package gces_pkg;
  typedef enum logic [1:0] {
    GCES_ARB_FW    = 2'h0,
    GCES_ARB_CB    = 2'h1,
    GCES_ARB_MEDIA = 2'h2,
    GCES_ARB_RR    = 2'h3
  } gces_arb_e;
  typedef logic [4:0] gces_pins_t;
endpackage : gces_pkg

// File: rtl/gces_evt_if.sv
// Purpose: Carries event sources from the pin watcher to the flag bank
// Assumes: Single clock domain
// Notes:   Pulses are one cycle wide
interface gces_evt_if;
  logic [4:0] pin_change;
  modport src (output pin_change);
  modport dst (input pin_change);
endinterface : gces_evt_if

// File: rtl/gces_pin_watch.sv
// Purpose: Synchronises multifunction pins and reports level changes
// Assumes: Pins are asynchronous to sys_clk
// Notes:   Change only reported while the pin is a general input
module gces_pin_watch (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        global_reset_n,
  input wire logic        clk_en,
  // Pins and routing
  input wire logic [4:0]  pins,
  input wire logic [4:0]  is_input,
  // Events
  gces_evt_if.src         evt
);
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] last_q;
  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
      last_q <= 5'h00;
    end else if (clk_en) begin
      meta_q <= pins;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  // Gated by clk_en so a frozen cycle does not repeat the pulse
  assign evt.pin_change = (sync_q ^ last_q) & is_input & {5{clk_en}};
endmodule : gces_pin_watch

// File: rtl/gces_query_timer.sv
// Purpose: Card-type query interval timer
// Assumes: Started by the media logic
// Notes:   Fast mode only shortens the interval
module gces_query_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic global_reset_n,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic fast,
  output logic     done
);
  `include "gces_cfg.svh"
  logic [15:0] cnt_q;
  logic        run_q;
  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= fast ? `GCES_QUERY_FAST : `GCES_QUERY_NORM;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == 16'h0000) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule : gces_query_timer

// File: rtl/gces_top.sv
// Purpose: General control register and event status register with event output
// Assumes: Byte-wide config accesses from function 0, one cycle per access
// Notes:   Only the global reset clears these registers
module gces_top
  import gces_pkg::*;
(
  // Clock, reset, enable
  input wire logic                 sys_clk,
  input wire logic                 global_reset_n,
  input wire logic                 clk_en,
  // Configuration access
  input wire logic                 cfg_wr,
  input wire logic                 cfg_rd,
  input wire logic [7:0]           cfg_addr,
  input wire logic [7:0]           cfg_wdata,
  output logic [7:0]               cfg_rdata,
  // Event sources and query start
  input wire logic                 power_change_ev,
  input wire logic                 prog_volt_change_ev,
  input wire logic                 multi_pin_5,
  input wire logic                 multi_pin_4,
  input wire logic                 multi_pin_2,
  input wire logic                 multi_pin_1,
  input wire logic                 multi_pin_0,
  input wire logic                 query_start,
  // Controls out
  output gces_pkg::gces_arb_e      arbitration_priority_sel,
  output logic                     firewire_func_off,
  output logic                     second_socket_off,
  output logic                     media_func_off,
  output logic                     io_limit_bit0,
  output logic                     io_base_bit0,
  output logic                     high_volt_switch_pick,
  output logic                     fast_query_sim,
  output logic                     query_done,
  output logic                     general_event_out_n
);
  import gces_pkg::*;
  `include "gces_cfg.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Literal macros cannot be sliced, so the masks are held in named constants
  localparam logic [15:0] GC_WMASK = `GCES_GC_WMASK;
  localparam logic [15:0] GC_RST   = `GCES_GC_RESET;
  logic [15:0]     gc_q;
  logic [7:0]      es_q;
  logic [7:0]      en_q;
  gces_pins_t      gpi_cfg_q;
  logic [7:0]      es_d;
  logic            tmr_done;
  gces_evt_if      evt ();

  gces_pin_watch u_pins (
    .sys_clk        (sys_clk),
    .global_reset_n (global_reset_n),
    .clk_en         (clk_en),
    .pins           ({multi_pin_5, multi_pin_4, multi_pin_2, multi_pin_1, multi_pin_0}),
    .is_input       (gpi_cfg_q),
    .evt            (evt)
  );

  gces_query_timer u_tmr (
    .sys_clk        (sys_clk),
    .global_reset_n (global_reset_n),
    .clk_en         (clk_en),
    .start          (query_start),
    .fast           (gc_q[`GCES_GC_FAST_SIM]),
    .done           (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = cfg_wr && (a == off);
  endfunction : hit

  // General control; only global reset clears it
  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      gc_q <= `GCES_GC_RESET;
    end else if (clk_en) begin
      if (hit(cfg_addr, `GCES_OFF_GEN_CTRL_LO)) begin
        gc_q[7:0] <= (cfg_wdata & GC_WMASK[7:0]) | GC_RST[7:0];
      end
      if (hit(cfg_addr, `GCES_OFF_GEN_CTRL_HI)) begin
        gc_q[15:8] <= cfg_wdata & GC_WMASK[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      en_q      <= 8'h00;
      gpi_cfg_q <= 5'h00;
    end else if (clk_en) begin
      if (hit(cfg_addr, `GCES_OFF_EVT_EN)) en_q <= cfg_wdata & `GCES_ES_MASK;
      if (hit(cfg_addr, `GCES_OFF_GPIO_CFG)) gpi_cfg_q <= cfg_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set wins over a simultaneous write-one clear
  always_comb begin
    es_d = es_q;
    if (hit(cfg_addr, `GCES_OFF_EVT_STS)) es_d = es_d & ~cfg_wdata;
    es_d[`GCES_ES_PWR] = es_d[`GCES_ES_PWR] | power_change_ev;
    es_d[`GCES_ES_VPP] = es_d[`GCES_ES_VPP] | prog_volt_change_ev;
    es_d[4:0] = es_d[4:0] | evt.pin_change;
    es_d = es_d & `GCES_ES_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      es_q <= `GCES_ES_RESET;
    end else if (clk_en) begin
      es_q <= es_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      arbitration_priority_sel <= GCES_ARB_FW;
      firewire_func_off        <= 1'b0;
      second_socket_off        <= 1'b0;
      media_func_off           <= 1'b0;
      io_limit_bit0            <= 1'b0;
      io_base_bit0             <= 1'b0;
      high_volt_switch_pick    <= 1'b0;
      fast_query_sim           <= 1'b0;
      query_done               <= 1'b0;
      general_event_out_n      <= 1'b1;
    end else if (clk_en) begin
      arbitration_priority_sel <= gces_arb_e'(gc_q[1:0]);
      firewire_func_off        <= gc_q[`GCES_GC_FW_OFF];
      second_socket_off        <= gc_q[`GCES_GC_SKTB_OFF];
      media_func_off           <= gc_q[`GCES_GC_MEDIA_OFF];
      io_limit_bit0            <= gc_q[`GCES_GC_IOLIM];
      io_base_bit0             <= gc_q[`GCES_GC_IOBASE];
      high_volt_switch_pick    <= gc_q[`GCES_GC_HV_SW];
      fast_query_sim           <= gc_q[`GCES_GC_FAST_SIM];
      query_done               <= tmr_done;
      general_event_out_n      <= ~|(es_q & en_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!global_reset_n) begin
      cfg_rdata <= 8'h00;
    end else if (clk_en) begin
      cfg_rdata <= 8'h00;
      if (cfg_rd) begin
        case (cfg_addr)
          `GCES_OFF_GEN_CTRL_LO: cfg_rdata <= gc_q[7:0];
          `GCES_OFF_GEN_CTRL_HI: cfg_rdata <= gc_q[15:8];
          `GCES_OFF_EVT_STS:     cfg_rdata <= es_q;
          `GCES_OFF_EVT_EN:      cfg_rdata <= en_q;
          `GCES_OFF_GPIO_CFG:    cfg_rdata <= {3'h0, gpi_cfg_q};
          default:               cfg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_es_clr;
    clk_en && cfg_wr && cfg_addr == `GCES_OFF_EVT_STS && cfg_wdata[7] && !power_change_ev;
  endsequence

  AST_REV_BIT: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    gc_q[7] == 1'b1) else $error("revision bit not one");
  AST_RSVD_GC: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    (gc_q & ~(`GCES_GC_WMASK | 16'h0080)) == 16'h0000) else $error("reserved set");
  AST_RSVD_ES: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    es_q[5] == 1'b0) else $error("status bit 5 set");
  AST_PWR_SET: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    clk_en && power_change_ev |=> es_q[7]) else $error("power flag missed");
  AST_VPP_SET: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    clk_en && prog_volt_change_ev |=> es_q[6]) else $error("vpp flag missed");
  AST_CLR: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    s_wr_es_clr |=> !es_q[7]) else $error("clear failed");
  AST_EVT_OUT: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    clk_en |=> general_event_out_n == ~|($past(es_q) & $past(en_q)))
    else $error("event output wrong");
  AST_ARB: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    clk_en |=> arbitration_priority_sel == gces_arb_e'($past(gc_q[1:0])))
    else $error("arbitration mismatch");
  AST_PIN: assert property (@(posedge sys_clk) disable iff (!global_reset_n)
    clk_en && evt.pin_change[0] |=> es_q[0]) else $error("pin flag missed");
endmodule : gces_top

// File: sim/gces_host_model.sv
// Purpose: Host side of configuration access, one byte per request
// Assumes: Requests launched at the falling edge, taken at the next rising edge
// Notes:   Released address and data show the inverse, never a held value
module gces_host_model (
  // Clock
  input wire logic       sys_clk,
  // Access
  output logic           cfg_wr,
  output logic           cfg_rd,
  output logic [7:0]     cfg_addr,
  output logic [7:0]     cfg_wdata,
  input wire logic [7:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr  = a;
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(negedge sys_clk);
    cfg_wr    = 1'b0;
    cfg_addr  = ~a;
    cfg_wdata = ~d;
  endtask : wr
  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_rd   = 1'b1;
    @(negedge sys_clk);
    cfg_rd   = 1'b0;
    cfg_addr = ~a;
    d        = cfg_rdata;
  endtask : rd
endmodule : gces_host_model

// File: sim/tb_gces_top.sv
// Purpose: Self-checking bench for the control and event bank
// Assumes: Host model drives all configuration requests
// Notes:   clk_en is held high throughout
`include "gces_cfg.svh"
module tb_gces_top;
  import gces_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, global_reset_n, clk_en, cfg_wr, cfg_rd, pwr_ev, vpp_ev, query_start;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, d;
  logic [4:0] pins;
  logic [15:0] v, e;
  gces_arb_e arb;
  logic fw, sktb, media, iolim, iobase, hv, fast, query_done, evt_n;
  int checks = 0, failures = 0, cyc = 0, n;
  gces_host_model host (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  gces_top dut (.sys_clk(sys_clk), .global_reset_n(global_reset_n), .clk_en(clk_en),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .power_change_ev(pwr_ev), .prog_volt_change_ev(vpp_ev),
    .multi_pin_5(pins[4]), .multi_pin_4(pins[3]), .multi_pin_2(pins[2]),
    .multi_pin_1(pins[1]), .multi_pin_0(pins[0]), .query_start(query_start),
    .arbitration_priority_sel(arb), .firewire_func_off(fw), .second_socket_off(sktb),
    .media_func_off(media), .io_limit_bit0(iolim), .io_base_bit0(iobase),
    .high_volt_switch_pick(hv), .fast_query_sim(fast), .query_done(query_done),
    .general_event_out_n(evt_n));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Long enough for the slow query plus all register traffic
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rc
  task automatic pulse(input int which);
    @(negedge sys_clk);
    if (which == 0) pwr_ev = 1'b1; else vpp_ev = 1'b1;
    @(negedge sys_clk);
    pwr_ev = 1'b0;
    vpp_ev = 1'b0;
  endtask : pulse
  task automatic run_query;
    @(negedge sys_clk);
    query_start = 1'b1;
    @(negedge sys_clk);
    query_start = 1'b0;
    n = 0;
    while (query_done !== 1'b1 && n < 8192) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : run_query
  task automatic do_reset;
    global_reset_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    global_reset_n = 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {global_reset_n, pwr_ev, vpp_ev, query_start} = 4'h0;
    clk_en = 1'b1;
    pins = 5'h00;
    do_reset();
    rc(`GCES_OFF_GEN_CTRL_LO, 8'h80);
    rc(`GCES_OFF_GEN_CTRL_HI, 8'h00);
    rc(`GCES_OFF_EVT_STS, `GCES_ES_RESET);
    rc(8'h90, 8'h00);
    $display("test reset done");
    for (int b = 0; b < 16; b++) begin
      v = 16'h0001 << b;
      host.wr(`GCES_OFF_GEN_CTRL_LO, v[7:0]);
      host.wr(`GCES_OFF_GEN_CTRL_HI, v[15:8]);
      repeat (2) @(negedge sys_clk);
      e = (v & `GCES_GC_WMASK) | `GCES_GC_RESET;
      rc(`GCES_OFF_GEN_CTRL_LO, e[7:0]);
      rc(`GCES_OFF_GEN_CTRL_HI, e[15:8]);
      chk({fast, iolim, iobase, hv, media, sktb, fw, arb}, {7'h00, e[13:10], e[5:3], e[1:0]});
    end
    host.wr(`GCES_OFF_GEN_CTRL_LO, 8'h03);
    repeat (2) @(negedge sys_clk);
    chk({14'h0, arb}, 16'h0003);
    $display("test control done");
    run_query();
    chk(16'(n), `GCES_QUERY_NORM + 16'h0002);
    host.wr(`GCES_OFF_GEN_CTRL_HI, 8'h20);
    run_query();
    chk(16'(n), `GCES_QUERY_FAST + 16'h0002);
    $display("test query done");
    host.wr(`GCES_OFF_EVT_EN, 8'hdf);
    pulse(0);
    repeat (2) @(negedge sys_clk);
    chk({15'h0, evt_n}, 16'h0000);
    rc(`GCES_OFF_EVT_STS, 8'h80);
    pulse(1);
    rc(`GCES_OFF_EVT_STS, 8'hc0);
    host.wr(`GCES_OFF_EVT_STS, 8'h40);
    rc(`GCES_OFF_EVT_STS, 8'h80);
    fork
      host.wr(`GCES_OFF_EVT_STS, 8'h80);
      pulse(0);
    join
    rc(`GCES_OFF_EVT_STS, 8'h80);
    host.wr(`GCES_OFF_EVT_EN, 8'h40);
    repeat (2) @(negedge sys_clk);
    chk({15'h0, evt_n}, 16'h0001);
    host.wr(`GCES_OFF_EVT_STS, 8'hff);
    rc(`GCES_OFF_EVT_STS, 8'h00);
    $display("test events done");
    pins = 5'h1f;
    repeat (6) @(negedge sys_clk);
    rc(`GCES_OFF_EVT_STS, 8'h00);
    host.wr(`GCES_OFF_GPIO_CFG, 8'h1f);
    for (int i = 0; i < 5; i++) begin
      pins[i] = ~pins[i];
      repeat (6) @(negedge sys_clk);
      rc(`GCES_OFF_EVT_STS, 8'h01 << i);
      host.wr(`GCES_OFF_EVT_STS, 8'h01 << i);
    end
    $display("test pins done");
    host.wr(`GCES_OFF_GEN_CTRL_HI, 8'hff);
    pulse(1);
    do_reset();
    rc(`GCES_OFF_GEN_CTRL_HI, 8'h00);
    rc(`GCES_OFF_EVT_STS, 8'h00);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : tb_gces_top
